// ===== src/apc_pkg.sv
// Package: offsets, field positions, reset values and widths
`default_nettype none
package apc_pkg;
   // ******************************************************
   // Widths
   // ******************************************************
   localparam int SINGLE_W   = 23;
   localparam int MULTI_W    = 16;
   localparam int REDUCED_W  = 9;
   localparam int WIDE_W     = 56;
   localparam int GEAR_W     = 16;
   localparam int ADDR_W     = 8;
   // ******************************************************
   // Register byte offsets
   // ******************************************************
   localparam logic [7:0] OFS_CTRL       = 8'h00;
   localparam logic [7:0] OFS_MT_LIMIT   = 8'h04;
   localparam logic [7:0] OFS_SCALE_HI   = 8'h08;
   localparam logic [7:0] OFS_SCALE_LO   = 8'h0c;
   localparam logic [7:0] OFS_GEAR       = 8'h10;
   localparam logic [7:0] OFS_HOME       = 8'h14;
   localparam logic [7:0] OFS_POLARITY   = 8'h18;
   localparam logic [7:0] OFS_STATUS     = 8'h1c;
   localparam logic [7:0] OFS_SINGLE_MON = 8'h20;
   localparam logic [7:0] OFS_MULTI_MON  = 8'h24;
   localparam logic [7:0] OFS_INTERNAL   = 8'h28;
   localparam logic [7:0] OFS_ACTUAL     = 8'h2c;
   // ******************************************************
   // Field positions
   // ******************************************************
   localparam int CTRL_SETUP_LSB   = 0;
   localparam int CTRL_SETUP_MSB   = 2;
   localparam int CTRL_REDUCED_BIT = 3;
   localparam int CTRL_CONT_BIT    = 4;
   localparam int CTRL_ENC_ERR_BIT = 5;
   localparam int STAT_POS_OVF_BIT = 0;
   localparam int STAT_ENC_OVF_BIT = 1;
   localparam int STAT_BACKUP_BIT  = 2;
   // ******************************************************
   // Reset values and constants
   // ******************************************************
   localparam logic [5:0]  CTRL_RESET     = 6'h00;
   localparam logic [15:0] MT_LIMIT_RESET = 16'hffff;
   localparam logic [15:0] MT_FULL_MAX    = 16'hffff;
   localparam logic [15:0] GEAR_RESET     = 16'h0001;
   localparam logic [15:0] GEAR_CHECK_MAX = 16'h0080;
   localparam logic [7:0]  POLARITY_NEG   = 8'he0;
endpackage
`default_nettype wire

// ===== src/apc_multiturn.sv
// Multi-turn count limiting and wrap detection
`default_nettype none
module apc_multiturn #(
   parameter int MW = apc_pkg::MULTI_W
) (
   input  wire logic          i_sys_clk,
   input  wire logic          i_reset,
   input  wire logic          i_valid,
   input  wire logic [MW-1:0] i_raw_turns,
   input  wire logic [MW-1:0] i_limit,
   input  wire logic          i_continuous,
   output logic      [MW-1:0] o_turns,
   output logic               o_valid,
   output logic               o_wrap
);
   logic [MW-1:0] max_turns;
   logic [MW-1:0] clamped;
   logic          seen;

   // Continuous mode uses the programmed ceiling, other modes the full range
   assign max_turns = i_continuous ? i_limit : MW'(apc_pkg::MT_FULL_MAX);
   assign clamped   = (i_raw_turns > max_turns) ? max_turns : i_raw_turns;

   // Count and wrap flag follow each encoder sample
   always_ff @(posedge i_sys_clk)
   begin
      if (i_reset)
      begin
         o_turns <= '0;
         o_valid <= 1'b0;
         o_wrap  <= 1'b0;
         seen    <= 1'b0;
      end
      else
      begin
         o_valid <= i_valid;
         o_wrap  <= 1'b0;
         if (i_valid)
         begin
            o_turns <= clamped;
            seen    <= 1'b1;
            // First sample has no history, so no wrap can be claimed
            o_wrap  <= seen && (((o_turns == max_turns) && (clamped == '0)) ||
                                ((o_turns == '0) && (clamped == max_turns)));
         end
      end
   end
endmodule
`default_nettype wire

// ===== src/apc_pos_calc.sv
// Gear conversion, polarity, home offset and overflow check
`default_nettype none
module apc_pos_calc #(
   parameter int WW = apc_pkg::WIDE_W,
   parameter int GW = apc_pkg::GEAR_W
) (
   input  wire logic                 i_sys_clk,
   input  wire logic                 i_reset,
   input  wire logic                 i_valid,
   input  wire logic signed [WW-1:0] i_wide,
   input  wire logic        [GW-1:0] i_gear,
   input  wire logic                 i_negate,
   input  wire logic        [31:0]   i_home,
   input  wire logic                 i_check_en,
   output logic                      o_valid,
   output logic             [31:0]   o_actual,
   output logic                      o_overflow
);
   localparam int PW = WW + GW + 1;
   logic signed [PW-1:0] product;
   logic signed [PW:0]   sum;

   // Signed product, sign turned for reverse polarity, then home offset
   assign product = PW'(i_wide * $signed({1'b0, i_gear}));
   assign sum     = (i_negate ? -(PW+1)'(product) : (PW+1)'(product)) +
                    (PW+1)'($signed(i_home));

   // Result and overflow registered together
   always_ff @(posedge i_sys_clk)
   begin
      if (i_reset)
      begin
         o_valid    <= 1'b0;
         o_actual   <= '0;
         o_overflow <= 1'b0;
      end
      else
      begin
         o_valid    <= i_valid;
         o_overflow <= 1'b0;
         if (i_valid)
         begin
            o_actual   <= sum[31:0];
            // Outside signed 32-bit range when the upper bits disagree with bit 31
            o_overflow <= i_check_en &&
                          (sum[PW:31] != {(PW-30){sum[31]}});
         end
      end
   end
endmodule
`default_nettype wire

// ===== src/apc_top.sv
// Absolute position composer: encoder capture, APB registers and position assembly
//
// What this block does
// - Single-turn position is unsigned 23 bits, 0 to 8388607, needs no backup.
// - Composite holds single-turn in low 23 bits, multi-turn in next 16.
// - Both counts increase for counterclockwise rotation seen from the shaft end.
// - Multi-turn wrap raises encoder overflow error only when control bit 5 selects it.
// - Multi-turn limited to programmed ceiling in continuous mode, else 65535.
// - Battery encoder keeps multi-turn on backup for setup 0, 2 or 4.
// - Internal position keeps the low 32 bits, nine effective multi-turn bits.
// - Internal position is turns times 2^23 plus single-turn plus scale offsets.
// - Actual is internal times gear plus home; polarity 224 negates the product.
// - Reduced select 0: all 16 turn bits signed, 65535 means -1.
// - Reduced select 1: upper 7 bits ignored, 9 bits signed, 511 means -1.
// - With reduced select 1 outside continuous mode, nonzero upper 7 bits give the same actual position as zero ones.
// - Actual beyond 32 bits raises counter overflow, full mode, gear below 128.
// - No counter overflow check with gear 128 or more, or reduced mode.
// - Multi-turn monitor shows unsigned 0 to 65535; signed form drives position.
// - Home offset shifts the range where counter overflow is detected.
// - Actual position is recomputed from encoder data after a reset.
`default_nettype none
module apc_top #(
   parameter int SW = apc_pkg::SINGLE_W,
   parameter int MW = apc_pkg::MULTI_W,
   parameter int GW = apc_pkg::GEAR_W
) (
   input  wire logic                       i_sys_clk,
   input  wire logic                       i_reset,
   // APB slave
   input  wire logic                       i_psel,
   input  wire logic                       i_penable,
   input  wire logic                       i_pwrite,
   input  wire logic [apc_pkg::ADDR_W-1:0] i_paddr,
   input  wire logic [31:0]                i_pwdata,
   input  wire logic [3:0]                 i_pstrb,
   output logic      [31:0]                o_prdata,
   output logic                            o_pready,
   output logic                            o_pslverr,
   // Encoder sample
   input  wire logic                       i_enc_valid,
   input  wire logic [SW-1:0]              i_enc_single,
   input  wire logic [MW-1:0]              i_enc_multi,
   input  wire logic                       i_battery_encoder,
   // Results
   output logic      [31:0]                o_actual_pos,
   output logic                            o_actual_valid,
   output logic                            o_pos_ovf_err,
   output logic                            o_enc_ovf_err,
   output logic                            o_backup_req
);
   localparam int WW = apc_pkg::WIDE_W;
   localparam int REDUCED_W_M1 = apc_pkg::REDUCED_W - 1;

   // ******************************************************
   // Functions
   // ******************************************************
   // Byte-lane merge for writable words
   function automatic logic [31:0] apc_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++)
      begin
         if (strb[i])
            r[8*i +: 8] = new_v[8*i +: 8];
      end
      return r;
   endfunction

   // Turns times 2^23 plus single-turn plus both scale offsets, full width
   function automatic logic signed [WW-1:0] apc_compose(input logic signed [WW-1:0] turns,
                                                        input logic [SW-1:0]        single,
                                                        input logic [31:0]          ofs_hi,
                                                        input logic [31:0]          ofs_lo);
      logic signed [WW-1:0] r;
      r = (turns <<< SW) + WW'(single) +
          (WW'($signed(ofs_hi)) <<< SW) + WW'($signed(ofs_lo));
      return r;
   endfunction

   // ******************************************************
   // Registers
   // ******************************************************
   logic [5:0]      ctrl;
   logic [MW-1:0]   mt_limit;
   logic [31:0]     scale_hi, scale_lo;
   logic [GW-1:0]   gear;
   logic [31:0]     home_ofs;
   logic [7:0]      polarity;
   logic            pos_ovf_flag, enc_ovf_flag;
   logic [SW-1:0]   single_mon;
   logic [MW-1:0]   multi_mon;
   logic [31:0]     internal_pos;

   logic            setup_phase, wr_now, rd_sel_ok, mapped, w1c_pos, w1c_enc;
   logic [31:0]     rd_data;

   logic            reduced, check_en, turns_valid, turns_wrap, calc_valid, calc_ovf;
   logic [MW-1:0]   turns;
   logic [SW-1:0]   single_q;
   logic signed [WW-1:0] turns_s;
   logic signed [WW-1:0] wide_pos;
   logic [31:0]     calc_actual;

   assign reduced = ctrl[apc_pkg::CTRL_REDUCED_BIT];

   // ******************************************************
   // APB decode
   // ******************************************************
   // Answer prepared in the setup cycle, so every access takes exactly two cycles
   assign setup_phase = i_psel && !i_penable;
   assign wr_now      = i_psel && i_penable && o_pready && i_pwrite && !o_pslverr;

   // Read multiplexer; reserved bits read as zero
   always_comb
   begin
      rd_data = 32'h0000_0000;
      mapped  = 1'b1;
      unique case (i_paddr)
         apc_pkg::OFS_CTRL:       rd_data = {26'h0, ctrl};
         apc_pkg::OFS_MT_LIMIT:   rd_data = {16'h0, mt_limit};
         apc_pkg::OFS_SCALE_HI:   rd_data = scale_hi;
         apc_pkg::OFS_SCALE_LO:   rd_data = scale_lo;
         apc_pkg::OFS_GEAR:       rd_data = {16'h0, gear};
         apc_pkg::OFS_HOME:       rd_data = home_ofs;
         apc_pkg::OFS_POLARITY:   rd_data = {24'h0, polarity};
         apc_pkg::OFS_STATUS:     rd_data = {29'h0, o_backup_req, enc_ovf_flag, pos_ovf_flag};
         apc_pkg::OFS_SINGLE_MON: rd_data = {9'h0, single_mon};
         apc_pkg::OFS_MULTI_MON:  rd_data = {16'h0, multi_mon};
         apc_pkg::OFS_INTERNAL:   rd_data = internal_pos;
         apc_pkg::OFS_ACTUAL:     rd_data = o_actual_pos;
         default:                 mapped  = 1'b0;
      endcase
   end

   // Read-only monitors refuse writes, unmapped offsets refuse both; other registers accept both directions
   assign rd_sel_ok = mapped && !(i_pwrite && (i_paddr inside {apc_pkg::OFS_SINGLE_MON, apc_pkg::OFS_MULTI_MON,
                                                               apc_pkg::OFS_INTERNAL, apc_pkg::OFS_ACTUAL}));

   // Bus answer flops
   always_ff @(posedge i_sys_clk)
   begin
      if (i_reset)
      begin
         o_pready  <= 1'b0;
         o_pslverr <= 1'b0;
         o_prdata  <= 32'h0000_0000;
      end
      else if (setup_phase)
      begin
         o_pready  <= 1'b1;
         o_pslverr <= !rd_sel_ok;
         o_prdata  <= (!i_pwrite && mapped) ? rd_data : 32'h0000_0000;
      end
      else
      begin
         o_pready  <= 1'b0;
         o_pslverr <= 1'b0;
      end
   end

   // ******************************************************
   // Configuration registers
   // ******************************************************
   // Software-written settings steering the position math
   always_ff @(posedge i_sys_clk)
   begin
      if (i_reset)
      begin
         ctrl     <= apc_pkg::CTRL_RESET;
         mt_limit <= apc_pkg::MT_LIMIT_RESET;
         scale_hi <= 32'h0000_0000;
         scale_lo <= 32'h0000_0000;
         gear     <= apc_pkg::GEAR_RESET;
         home_ofs <= 32'h0000_0000;
         polarity <= 8'h00;
      end
      else if (wr_now)
      begin
         unique case (i_paddr)
            apc_pkg::OFS_CTRL:     ctrl     <= 6'(apc_merge({26'h0, ctrl}, i_pwdata, i_pstrb));
            apc_pkg::OFS_MT_LIMIT: mt_limit <= MW'(apc_merge({16'h0, mt_limit}, i_pwdata, i_pstrb));
            apc_pkg::OFS_SCALE_HI: scale_hi <= apc_merge(scale_hi, i_pwdata, i_pstrb);
            apc_pkg::OFS_SCALE_LO: scale_lo <= apc_merge(scale_lo, i_pwdata, i_pstrb);
            apc_pkg::OFS_GEAR:     gear     <= GW'(apc_merge({16'h0, gear}, i_pwdata, i_pstrb));
            apc_pkg::OFS_HOME:     home_ofs <= apc_merge(home_ofs, i_pwdata, i_pstrb);
            apc_pkg::OFS_POLARITY: polarity <= 8'(apc_merge({24'h0, polarity}, i_pwdata, i_pstrb));
            default:               ;
         endcase
      end
   end

   // ******************************************************
   // Encoder capture
   // ******************************************************
   // Counts are taken as delivered; they rise for counterclockwise shaft motion
   always_ff @(posedge i_sys_clk)
   begin
      if (i_reset)
         single_q <= '0;
      else if (i_enc_valid)
         single_q <= i_enc_single;
   end

   apc_multiturn #(
      .MW (MW)
   ) u_multiturn (
      .i_sys_clk    (i_sys_clk),
      .i_reset      (i_reset),
      .i_valid      (i_enc_valid),
      .i_raw_turns  (i_enc_multi),
      .i_limit      (mt_limit),
      .i_continuous (ctrl[apc_pkg::CTRL_CONT_BIT]),
      .o_turns      (turns),
      .o_valid      (turns_valid),
      .o_wrap       (turns_wrap)
   );

   // ******************************************************
   // Position assembly
   // ******************************************************
   // Signed turn view: 16 bits, or 9 bits with the upper 7 dropped
   assign turns_s  = reduced ? WW'($signed(turns[REDUCED_W_M1:0]))
                             : WW'($signed(turns));
   assign wide_pos = apc_compose(turns_s, single_q, scale_hi, scale_lo);

   // Overflow check only in full mode with a small gear multiplier
   assign check_en = !reduced && (gear < apc_pkg::GEAR_CHECK_MAX);

   // Monitors and low-32 internal position, refreshed every sample
   always_ff @(posedge i_sys_clk)
   begin
      if (i_reset)
      begin
         single_mon   <= '0;
         multi_mon    <= '0;
         internal_pos <= 32'h0000_0000;
      end
      else if (turns_valid)
      begin
         single_mon   <= single_q;
         multi_mon    <= turns;
         internal_pos <= wide_pos[31:0];
      end
   end

   apc_pos_calc #(
      .WW (WW),
      .GW (GW)
   ) u_pos_calc (
      .i_sys_clk  (i_sys_clk),
      .i_reset    (i_reset),
      .i_valid    (turns_valid),
      .i_wide     (wide_pos),
      .i_gear     (gear),
      .i_negate   (polarity == apc_pkg::POLARITY_NEG),
      .i_home     (home_ofs),
      .i_check_en (check_en),
      .o_valid    (calc_valid),
      .o_actual   (calc_actual),
      .o_overflow (calc_ovf)
   );

   // Actual position from encoder data and settings alone, so a reset re-derives it
   always_ff @(posedge i_sys_clk)
   begin
      if (i_reset)
      begin
         o_actual_pos   <= 32'h0000_0000;
         o_actual_valid <= 1'b0;
      end
      else
      begin
         o_actual_valid <= calc_valid;
         if (calc_valid)
            o_actual_pos <= calc_actual;
      end
   end

   // ******************************************************
   // Error flags
   // ******************************************************
   // Write one to clear; a new event in the same cycle wins
   assign w1c_pos = wr_now && (i_paddr == apc_pkg::OFS_STATUS) && i_pstrb[0] &&
                    i_pwdata[apc_pkg::STAT_POS_OVF_BIT];
   assign w1c_enc = wr_now && (i_paddr == apc_pkg::OFS_STATUS) && i_pstrb[0] &&
                    i_pwdata[apc_pkg::STAT_ENC_OVF_BIT];

   always_ff @(posedge i_sys_clk)
   begin
      if (i_reset)
         pos_ovf_flag <= 1'b0;
      else if (calc_ovf)
         pos_ovf_flag <= 1'b1;
      else if (w1c_pos)
         pos_ovf_flag <= 1'b0;
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (i_reset)
         enc_ovf_flag <= 1'b0;
      else if (turns_wrap && ctrl[apc_pkg::CTRL_ENC_ERR_BIT])
         enc_ovf_flag <= 1'b1;
      else if (w1c_enc)
         enc_ovf_flag <= 1'b0;
   end

   // Error outputs mirror the flags one cycle later, keeping them flop-driven
   always_ff @(posedge i_sys_clk)
   begin
      if (i_reset)
      begin
         o_pos_ovf_err <= 1'b0;
         o_enc_ovf_err <= 1'b0;
         o_backup_req  <= 1'b0;
      end
      else
      begin
         o_pos_ovf_err <= pos_ovf_flag;
         o_enc_ovf_err <= enc_ovf_flag;
         // Battery upkeep of turns only for setup codes 0, 2 and 4
         o_backup_req  <= i_battery_encoder &&
                          (ctrl[apc_pkg::CTRL_SETUP_MSB:apc_pkg::CTRL_SETUP_LSB] inside
                           {3'h0, 3'h2, 3'h4});
      end
   end
endmodule
`default_nettype wire

// ===== src/apc_top_dummy_guard.sv
// Empty companion: no logic
`default_nettype none
`default_nettype wire

// ===== tb/apc_top_asserts.sv
// Checker of the position composer's port behaviour
`default_nettype none
module apc_chk (
   input wire logic        i_sys_clk,
   input wire logic        i_reset,
   input wire logic        i_psel,
   input wire logic        i_penable,
   input wire logic        i_pwrite,
   input wire logic        o_pready,
   input wire logic        o_pslverr,
   input wire logic        i_enc_valid,
   input wire logic        i_battery_encoder,
   input wire logic [31:0] o_actual_pos,
   input wire logic        o_actual_valid,
   input wire logic        o_pos_ovf_err,
   input wire logic        o_enc_ovf_err,
   input wire logic        o_backup_req
);
   // Completed bus write, the only flag clear
   wire logic wr = i_psel && i_penable && i_pwrite;
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (i_reset);
   // ******************************************************
   // Assertions
   // ******************************************************
   // Result follows a sample after exactly three cycles
   property p_lat; i_enc_valid |-> ##3 o_actual_valid; endproperty
   a_lat: assert property (p_lat) else $error("no result");
   property p_cause; o_actual_valid |-> $past(i_enc_valid, 3); endproperty
   a_cause: assert property (p_cause) else $error("stray result");
   // Position moves only with its pulse; reset edge excused
   property p_hold; !o_actual_valid && !$past(i_reset) |-> $stable(o_actual_pos); endproperty
   a_hold: assert property (p_hold) else $error("stray move");
   // Flags can only rise behind an encoder sample
   property p_povf; $rose(o_pos_ovf_err) |-> $past(i_enc_valid, 3) || $past(i_enc_valid, 4); endproperty
   a_povf: assert property (p_povf) else $error("stray counter flag");
   property p_eovf; $rose(o_enc_ovf_err) |-> $past(i_enc_valid, 3) || $past(i_enc_valid, 4); endproperty
   a_eovf: assert property (p_eovf) else $error("stray encoder flag");
   property p_sticky;
      $fell(o_pos_ovf_err) |-> $past(i_reset) || $past(wr) || $past(wr, 2) || $past(wr, 3);
   endproperty
   a_sticky: assert property (p_sticky) else $error("counter flag lost");
   property p_bkp; !i_battery_encoder ##1 !i_battery_encoder |-> !o_backup_req; endproperty
   a_bkp: assert property (p_bkp) else $error("stray backup");
   property p_rdy; i_psel && !i_penable |=> o_pready ##1 !o_pready; endproperty
   a_rdy: assert property (p_rdy) else $error("answer length");
   property p_err; o_pslverr |-> o_pready; endproperty
   a_err: assert property (p_err) else $error("stray error");
   c_povf: cover property (o_pos_ovf_err);
   c_eovf: cover property (o_enc_ovf_err);
   c_perr: cover property (o_pslverr);
   c_bkp: cover property (o_backup_req);
endmodule
bind apc_top apc_chk u_chk (.i_sys_clk, .i_reset, .i_psel, .i_penable, .i_pwrite, .o_pready, .o_pslverr,
   .i_enc_valid, .i_battery_encoder, .o_actual_pos, .o_actual_valid, .o_pos_ovf_err, .o_enc_ovf_err, .o_backup_req);
`default_nettype wire

// ===== tb/apc_host_model.sv
// Host controller model: bus master reading and writing the position registers
`default_nettype none
module apc_host_model (
   input  wire logic        i_sys_clk,
   input  wire logic [31:0] i_prdata,
   input  wire logic        i_pready,
   input  wire logic        i_pslverr,
   output logic             o_psel,
   output logic             o_penable,
   output logic             o_pwrite,
   output logic [7:0]       o_paddr,
   output logic [31:0]      o_pwdata,
   output logic [3:0]       o_pstrb
);
   timeunit 1ns;
   timeprecision 1ns;
   // Idle bus; whole words only, no motion commands are ever issued
   initial {o_psel, o_penable, o_pwrite, o_paddr, o_pwdata, o_pstrb} = {3'h0, 8'h00, 32'h0, 4'hf};
   // One transfer held until ready; hung flags a stuck slave
   task automatic xfer(input logic wr, input logic [7:0] adr, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err, output bit hung);
      int k;
      hung = 1'b1;
      @(posedge i_sys_clk);
      o_psel    <= 1'b1;
      o_penable <= 1'b0;
      o_pwrite  <= wr;
      o_paddr   <= adr;
      o_pwdata  <= wd;
      @(posedge i_sys_clk);
      o_penable <= 1'b1;
      for (k = 0; k < 20 && hung; k++)
      begin
         @(posedge i_sys_clk);
         if (i_pready === 1'b1)
         begin
            hung = 1'b0;
            rd   = i_prdata;
            err  = i_pslverr;
         end
      end
      o_psel    <= 1'b0;
      o_penable <= 1'b0;
   endtask
endmodule
`default_nettype wire

// ===== tb/absolute_position_composer_test.sv
// Self-checking bench of the absolute position composer
`default_nettype none
module absolute_position_composer_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk, rst, psel, pen, pwr, prdy, perr, enc_v, batt, act_v, pos_err, enc_err, bkp;
   logic [7:0]  paddr;
   logic [3:0]  pstrb;
   logic [22:0] enc_s;
   logic [15:0] enc_m;
   logic [31:0] pwdata, prdata, act_pos, q, r, r2;
   logic [31:0] c_ctrl, c_lim, c_gear, c_pol, c_home, c_hi, c_lo;
   logic        e;
   int          n_errors = 0;
   int          n_tests  = 0;
   int          i;
   logic [31:0] seed     = 32'h0000_9d8a;
   apc_top u_dut (.i_sys_clk(clk), .i_reset(rst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
      .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb), .o_prdata(prdata), .o_pready(prdy),
      .o_pslverr(perr), .i_enc_valid(enc_v), .i_enc_single(enc_s), .i_enc_multi(enc_m),
      .i_battery_encoder(batt), .o_actual_pos(act_pos), .o_actual_valid(act_v),
      .o_pos_ovf_err(pos_err), .o_enc_ovf_err(enc_err), .o_backup_req(bkp));
   apc_host_model u_host (.i_sys_clk(clk), .i_prdata(prdata), .i_pready(prdy), .i_pslverr(perr),
      .o_psel(psel), .o_penable(pen), .o_pwrite(pwr), .o_paddr(paddr), .o_pwdata(pwdata), .o_pstrb(pstrb));
   // 100 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      n_tests++;
      if (got !== ex)
      begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, ex, got);
      end
   endtask
   // Bus access; a hung slave ends the run
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      bit h;
      u_host.xfer(wr, a, d, q, e, h);
      if (h)
      begin
         n_errors++;
         tally_and_finish();
      end
   endtask
   task automatic cfg(input logic [31:0] ctl, lim, gr, pl, hm, hi, lo);
      {c_ctrl, c_lim, c_gear, c_pol, c_home, c_hi, c_lo} = {ctl, lim, gr, pl, hm, hi, lo};
      bus(1'b1, apc_pkg::OFS_CTRL, ctl);
      bus(1'b1, apc_pkg::OFS_MT_LIMIT, lim);
      bus(1'b1, apc_pkg::OFS_GEAR, gr);
      bus(1'b1, apc_pkg::OFS_POLARITY, pl);
      bus(1'b1, apc_pkg::OFS_HOME, hm);
      bus(1'b1, apc_pkg::OFS_SCALE_HI, hi);
      bus(1'b1, apc_pkg::OFS_SCALE_LO, lo);
   endtask
   // Sample in, 64-bit reference model, compare every result
   task automatic send(input logic [22:0] s, input logic [15:0] m);
      longint t, w, p;
      logic [15:0] mc;
      int k;
      bus(1'b1, apc_pkg::OFS_STATUS, 32'h3);
      mc = (c_ctrl[4] && m > c_lim[15:0]) ? c_lim[15:0] : m;
      t = c_ctrl[3] ? longint'($signed(mc[8:0])) : longint'($signed(mc));
      w = (t + longint'($signed(c_hi))) * 64'sh800000 + s + longint'($signed(c_lo));
      p = w * longint'(c_gear[15:0]);
      p = (c_pol[7:0] == 8'he0) ? -p : p;
      p = p + longint'($signed(c_home));
      enc_v <= 1'b1;
      enc_s <= s;
      enc_m <= m;
      @(posedge clk);
      enc_v <= 1'b0;
      for (k = 0; k < 10 && act_v !== 1'b1; k++)
         @(posedge clk);
      if (k == 10)
      begin
         n_errors++;
         tally_and_finish();
      end
      chk("actual position", p[31:0], act_pos);
      repeat (2) @(posedge clk);
      chk("counter overflow", 32'(!c_ctrl[3] && c_gear < 128 && p != longint'(int'(p))), 32'(pos_err));
      bus(1'b0, apc_pkg::OFS_SINGLE_MON, 32'h0);
      chk("single monitor", {9'h0, s}, q);
      bus(1'b0, apc_pkg::OFS_MULTI_MON, 32'h0);
      chk("multi monitor", {16'h0, mc}, q);
      bus(1'b0, apc_pkg::OFS_INTERNAL, 32'h0);
      chk("internal position", w[31:0], q);
   endtask
   initial
   begin
      {rst, enc_v, enc_s, enc_m, batt} = {1'b1, 1'b0, 23'h0, 16'h0, 1'b0};
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      // Reset values, then refused accesses
      bus(1'b0, apc_pkg::OFS_MT_LIMIT, 32'h0);
      chk("limit reset", 32'h0000_ffff, q);
      bus(1'b0, apc_pkg::OFS_GEAR, 32'h0);
      chk("gear reset", 32'h1, q);
      bus(1'b0, 8'h30, 32'h0);
      chk("unmapped error", 32'h1, 32'(e));
      bus(1'b1, apc_pkg::OFS_MULTI_MON, 32'h1234);
      chk("monitor write error", 32'h1, 32'(e));
      $display("test registers done");
      // Random configurations with boundary counts first
      for (i = 0; i < 24; i++)
      begin
         r  = rnd();
         r2 = rnd();
         cfg({28'h0, r[0], 3'h0}, 32'hffff, {24'h0, r[8:1]} + 1, r[9] ? 32'he0 : 32'h0, rnd(),
             {{28{r[13]}}, r[13:10]}, rnd());
         send(i == 0 ? 23'h7fffff : r2[22:0], i < 2 ? 16'hffff : r2[31:16]);
      end
      $display("test positions done");
      // Turn wrap: error enabled, disabled, and with a ceiling
      for (i = 0; i < 3; i++)
      begin
         cfg(i == 1 ? 32'h00 : (i == 0 ? 32'h20 : 32'h30), i == 2 ? 32'h64 : 32'hffff, 32'h1, 32'h0, 32'h0, 32'h0,
             32'h0);
         send(23'h0, i == 2 ? 16'h0096 : 16'hffff);
         send(23'h0, 16'h0);
         chk("encoder overflow", 32'(i != 1), 32'(enc_err));
      end
      $display("test turn wrap done");
      // Backup request for setup codes 0 to 4
      batt <= 1'b1;
      for (i = 0; i < 5; i++)
      begin
         bus(1'b1, apc_pkg::OFS_CTRL, 32'(i));
         repeat (2) @(posedge clk);
         chk("backup request", 32'(i % 2 == 0), 32'(bkp));
      end
      batt <= 1'b0;
      repeat (2) @(posedge clk);
      chk("backup without battery", 32'h0, 32'(bkp));
      $display("test backup done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
